// ===== src/clss_pkg.sv
/*
 Constants, register map and state type for the command list
 start/stop interpreter. Assumes nothing of its surroundings.
*/
package clss_pkg;
	// Command codes, marker and error codes
	localparam logic [7:0] CMD_START = 8'h01;
	localparam logic [7:0] CMD_STOP = 8'h02;
	localparam logic [7:0] BOARD_MARKER = 8'hFF;
	localparam logic [7:0] ERR_LIST_STATE = 8'h11;
	localparam logic [7:0] ERR_BAD_MARKER = 8'h20;
	localparam logic [7:0] ERR_BAD_CMD = 8'h21;
	// Register byte offsets
	localparam logic [7:0] OFS_PB_IDENT = 8'h00;
	localparam logic [7:0] OFS_PB_W04 = 8'h04;
	localparam logic [7:0] OFS_PB_W08 = 8'h08;
	localparam logic [7:0] OFS_PB_W0C = 8'h0C;
	localparam logic [7:0] OFS_PB_W10 = 8'h10;
	localparam logic [7:0] OFS_CTRL = 8'h14;
	localparam logic [7:0] OFS_SB_IDENT = 8'h18;
	localparam logic [7:0] OFS_SB_W04 = 8'h1C;
	localparam logic [7:0] OFS_STATE = 8'h20;
	localparam logic [7:0] OFS_INT_STAT = 8'h24;
	localparam logic [7:0] OFS_INT_MASK = 8'h28;
	localparam logic [7:0] OFS_LIST_ADDR = 8'h2C;
	localparam logic [7:0] OFS_LIST_CFG = 8'h30;
	// Field positions; byte 0 of a word is bits 31:24
	localparam int MARKER_LSB = 0;
	localparam int AM_LSB = 8;
	localparam int CMD_LSB = 24;
	localparam int INT_LVL_LSB = 8;
	localparam int INT_ZERO_LSB = 11;
	localparam int VEC_LSB = 0;
	localparam int FLAG_CC = 7;
	localparam int FLAG_ERR = 6;
	localparam int SB_ERR_LSB = 8;
	localparam int CTRL_GO = 0;
	localparam int IST_DONE = 0;
	localparam int IST_REFUSED = 1;
	localparam int ST_RUN = 0;
	localparam int ST_STOPPING = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_CNT_LSB = 8;
	// Reset values and response codes
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RST_INT = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {CLSS_IDLE, CLSS_DECODE, CLSS_DRAIN, CLSS_FINISH}
		clss_state_e;
endpackage

// ===== src/clss_top.sv
/*
 Command list start/stop interpreter with AXI4-Lite register slave.
 Assumes software copies each parameter block into the block registers,
 and that a list engine outside reports queued entries and completions.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
// Summary of operation
// - Code 01H decodes as list start
// - Start fields read from fixed byte slots
// - Marker FFH identifies board-control command
// - Stored modifier drives bus during list access
// - List address points at input index
// - Interrupt level bits 10:8, zero disables
// - Low byte answered as acknowledge vector
// - Identifier word copied into status block
// - Code 02H decodes as list stop
// - After stop, no new queue entries
// - Stop status word written at decode; done interrupt waits for queue drain
// - Stop block uses identifier, marker, code only
// - Stop while not running fails with 11H
// - Finished and error flags, error byte
`timescale 1ns/1ns
module clss_top #(
	parameter int CNT_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic entry_valid,
	output logic entry_ready,
	input wire logic entry_done,
	input wire logic list_mem_req,
	output logic [7:0] vme_am,
	output logic [31:0] list_addr,
	output logic list_running,
	output logic [2:0] irq_level,
	input wire logic iack_req,
	output logic [7:0] iack_vector,
	output logic iack_valid,
	output logic irq
);
	logic [31:0] pb_r [5];
	logic [31:0] pb_nxt [5];
	logic [7:0] awaddr_r, awaddr_nxt;
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	clss_pkg::clss_state_e state_r, state_nxt;
	logic run_r, run_nxt, stopping_r, stopping_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [31:0] sb_id_r, sb_id_nxt, sb_w04_r, sb_w04_nxt;
	logic [31:0] ladr_r, ladr_nxt;
	logic [7:0] am_r, am_nxt;
	logic [15:0] intf_r, intf_nxt;
	logic [1:0] ist_r, ist_nxt, imask_r, imask_nxt;
	logic [7:0] vec_r, vec_nxt;
	logic vecv_r, vecv_nxt;
	logic do_wr, do_rd, go, take, wr_ok, rd_ok;
	logic [7:0] code, err;
	logic [31:0] rval;
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return m;
	endfunction
	always_comb begin
		pb_nxt = pb_r;
		awaddr_nxt = awaddr_r;
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		state_nxt = state_r;
		run_nxt = run_r;
		stopping_nxt = stopping_r;
		cnt_nxt = cnt_r;
		sb_id_nxt = sb_id_r;
		sb_w04_nxt = sb_w04_r;
		ladr_nxt = ladr_r;
		am_nxt = am_r;
		intf_nxt = intf_r;
		ist_nxt = ist_r;
		imask_nxt = imask_r;
		vec_nxt = vec_r;
		vecv_nxt = 1'b0;
		go = 1'b0;
		wr_ok = 1'b1;
		rd_ok = 1'b1;
		rval = clss_pkg::RST_WORD;
		code = pb_r[4][clss_pkg::CMD_LSB +: 8];
		err = 8'h00;
		// Write channels taken in either order, answered once both held
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_nxt = s_axi_awaddr;
			aw_held_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
			w_held_nxt = 1'b1;
		end
		do_wr = aw_held_r && w_held_r && !bvalid_r;
		if (do_wr) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			case (awaddr_r)
			clss_pkg::OFS_PB_IDENT: pb_nxt[0] = merge(pb_r[0], wdata_r, wstrb_r);
			clss_pkg::OFS_PB_W04: pb_nxt[1] = merge(pb_r[1], wdata_r, wstrb_r);
			clss_pkg::OFS_PB_W08: pb_nxt[2] = merge(pb_r[2], wdata_r, wstrb_r);
			clss_pkg::OFS_PB_W0C: pb_nxt[3] = merge(pb_r[3], wdata_r, wstrb_r);
			clss_pkg::OFS_PB_W10: pb_nxt[4] = merge(pb_r[4], wdata_r, wstrb_r);
			clss_pkg::OFS_CTRL: go = wstrb_r[0] && wdata_r[clss_pkg::CTRL_GO];
			clss_pkg::OFS_INT_MASK: imask_nxt = wstrb_r[0] ? wdata_r[1:0] : imask_r;
			clss_pkg::OFS_SB_IDENT, clss_pkg::OFS_SB_W04, clss_pkg::OFS_STATE,
			clss_pkg::OFS_INT_STAT, clss_pkg::OFS_LIST_ADDR,
			clss_pkg::OFS_LIST_CFG: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
			endcase
			bresp_nxt = wr_ok ? clss_pkg::RESP_OKAY : clss_pkg::RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		// Read path
		case (s_axi_araddr)
		clss_pkg::OFS_PB_IDENT: rval = pb_r[0];
		clss_pkg::OFS_PB_W04: rval = pb_r[1];
		clss_pkg::OFS_PB_W08: rval = pb_r[2];
		clss_pkg::OFS_PB_W0C: rval = pb_r[3];
		clss_pkg::OFS_PB_W10: rval = pb_r[4];
		clss_pkg::OFS_CTRL: rval = clss_pkg::RST_WORD;
		clss_pkg::OFS_SB_IDENT: rval = sb_id_r;
		clss_pkg::OFS_SB_W04: rval = sb_w04_r;
		clss_pkg::OFS_STATE: begin
			rval[clss_pkg::ST_RUN] = run_r;
			rval[clss_pkg::ST_STOPPING] = stopping_r;
			rval[clss_pkg::ST_BUSY] = (state_r != clss_pkg::CLSS_IDLE);
			rval[clss_pkg::ST_CNT_LSB +: CNT_W] = cnt_r;
		end
		clss_pkg::OFS_INT_STAT: rval[1:0] = ist_r;
		clss_pkg::OFS_INT_MASK: rval[1:0] = imask_r;
		clss_pkg::OFS_LIST_ADDR: rval = ladr_r;
		clss_pkg::OFS_LIST_CFG: rval = {8'h00, am_r, intf_r};
		default: rd_ok = 1'b0;
		endcase
		do_rd = s_axi_arvalid && s_axi_arready;
		if (do_rd) begin
			rdata_nxt = rval;
			rresp_nxt = rd_ok ? clss_pkg::RESP_OKAY : clss_pkg::RESP_SLVERR;
			rvalid_nxt = 1'b1;
			if (s_axi_araddr == clss_pkg::OFS_INT_STAT) begin
				ist_nxt = 2'h0;
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		// Queue occupancy; a stop closes the queue
		take = entry_valid && entry_ready;
		if (take && !entry_done) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (!take && entry_done && cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		if (entry_valid && !entry_ready) begin
			ist_nxt[clss_pkg::IST_REFUSED] = 1'b1;
		end
		// Command interpreter
		case (state_r)
		clss_pkg::CLSS_IDLE: begin
			if (go) begin
				state_nxt = clss_pkg::CLSS_DECODE;
			end
		end
		clss_pkg::CLSS_DECODE: begin
			state_nxt = clss_pkg::CLSS_FINISH;
			if (pb_r[1][clss_pkg::MARKER_LSB +: 8] != clss_pkg::BOARD_MARKER) begin
				err = clss_pkg::ERR_BAD_MARKER;
			end else if (code == clss_pkg::CMD_START) begin
				if (run_r) begin
					err = clss_pkg::ERR_LIST_STATE;
				end else begin
					run_nxt = 1'b1;
					am_nxt = pb_r[1][clss_pkg::AM_LSB +: 8];
					ladr_nxt = pb_r[2];
					intf_nxt = pb_r[3][15:0];
				end
			end else if (code == clss_pkg::CMD_STOP) begin
				if (!run_r) begin
					err = clss_pkg::ERR_LIST_STATE;
				end else begin
					stopping_nxt = 1'b1;
					state_nxt = clss_pkg::CLSS_DRAIN;
				end
			end else begin
				err = clss_pkg::ERR_BAD_CMD;
			end
			sb_id_nxt = pb_r[0];
			sb_w04_nxt = RST_W04(err);
		end
		clss_pkg::CLSS_DRAIN: begin
			// Every queued entry must report status first
			if (cnt_r == '0 && !take) begin
				run_nxt = 1'b0;
				stopping_nxt = 1'b0;
				state_nxt = clss_pkg::CLSS_FINISH;
				sb_w04_nxt = RST_W04(8'h00);
			end
		end
		clss_pkg::CLSS_FINISH: begin
			ist_nxt[clss_pkg::IST_DONE] = 1'b1;
			state_nxt = clss_pkg::CLSS_IDLE;
		end
		default: state_nxt = clss_pkg::CLSS_IDLE;
		endcase
		// Acknowledge vector from the low byte
		if (iack_req) begin
			vec_nxt = intf_r[clss_pkg::VEC_LSB +: 8];
			vecv_nxt = 1'b1;
		end
	end
	// Status word: error byte beside finished/error flags
	function automatic logic [31:0] RST_W04(input logic [7:0] e);
		logic [31:0] w;
		w = clss_pkg::RST_WORD;
		w[clss_pkg::SB_ERR_LSB +: 8] = e;
		w[clss_pkg::FLAG_CC] = 1'b1;
		w[clss_pkg::FLAG_ERR] = (e != 8'h00);
		return w;
	endfunction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 5; i++) begin
				pb_r[i] <= clss_pkg::RST_WORD;
			end
			awaddr_r <= 8'h00;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			wdata_r <= clss_pkg::RST_WORD;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= clss_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= clss_pkg::RESP_OKAY;
			rdata_r <= clss_pkg::RST_WORD;
			state_r <= clss_pkg::CLSS_IDLE;
			run_r <= 1'b0;
			stopping_r <= 1'b0;
			cnt_r <= '0;
			sb_id_r <= clss_pkg::RST_WORD;
			sb_w04_r <= clss_pkg::RST_WORD;
			ladr_r <= clss_pkg::RST_WORD;
			am_r <= 8'h00;
			intf_r <= 16'h0000;
			ist_r <= clss_pkg::RST_INT;
			imask_r <= clss_pkg::RST_INT;
			vec_r <= 8'h00;
			vecv_r <= 1'b0;
		end else begin
			pb_r <= pb_nxt;
			awaddr_r <= awaddr_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			state_r <= state_nxt;
			run_r <= run_nxt;
			stopping_r <= stopping_nxt;
			cnt_r <= cnt_nxt;
			sb_id_r <= sb_id_nxt;
			sb_w04_r <= sb_w04_nxt;
			ladr_r <= ladr_nxt;
			am_r <= am_nxt;
			intf_r <= intf_nxt;
			ist_r <= ist_nxt;
			imask_r <= imask_nxt;
			vec_r <= vec_nxt;
			vecv_r <= vecv_nxt;
		end
	end

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	// Full counter also closes the queue, so it never wraps
	assign entry_ready = run_r && !stopping_r && (cnt_r != '1);
	assign vme_am = list_mem_req ? am_r : 8'h00;
	assign list_addr = ladr_r;
	assign list_running = run_r;
	// Upper bits are expected zero; level taken as is
	assign irq_level = run_r ? intf_r[clss_pkg::INT_LVL_LSB +: 3] : 3'h0;
	assign iack_vector = vec_r;
	assign iack_valid = vecv_r;
	assign irq = |(ist_r & imask_r);
endmodule

// ===== sim/clss_properties.sv
/*
 Port timing checker for clss_top.
 Assumes a bind from the bench top file.
*/
`timescale 1ns/1ns
module clss_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic entry_ready,
	input wire logic list_mem_req,
	input wire logic [7:0] vme_am,
	input wire logic [31:0] list_addr,
	input wire logic list_running,
	input wire logic [2:0] irq_level,
	input wire logic iack_req,
	input wire logic iack_valid
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_vec;
		##1 iack_valid;
	endsequence
	a_am_gate: assert property (!list_mem_req |-> vme_am == 8'h00)
		else $error("modifier driven outside list access");
	a_level_off: assert property (!list_running |-> irq_level == 3'h0)
		else $error("level shown while stopped");
	a_vec_pulse: assert property (iack_req |-> s_vec)
		else $error("vector not answered");
	a_vec_cause: assert property (iack_valid |-> $past(iack_req))
		else $error("vector without acknowledge");
	a_queue_shut: assert property (!list_running |-> !entry_ready)
		else $error("queue open while stopped");
	a_addr_hold: assert property (list_running && $past(list_running)
		|-> $stable(list_addr)) else $error("list address moved");
	a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
endmodule

// ===== sim/clss_list_model.sv
/*
 List engine model: offers queue entries and completes them slowly.
 Assumes the bench holds offer until an entry is taken.
*/
`timescale 1ns/1ns
module clss_list_model #(
	parameter int DLY = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic offer,
	input wire logic entry_ready,
	output logic entry_valid,
	output logic entry_done,
	output logic list_mem_req,
	output int pend
);
	int t;
	wire logic take = entry_valid && entry_ready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			entry_valid <= 1'b0;
			entry_done <= 1'b0;
			list_mem_req <= 1'b0;
			pend <= 0;
			t <= 0;
		end else begin
			// Dropped at the take edge so one offer is one entry
			entry_valid <= offer && !take;
			// Slow completions keep entries queued across a stop
			entry_done <= pend > 0 && t == DLY;
			t <= (pend > 0 && t < DLY) ? t + 1 : 0;
			pend <= pend + int'(take) - int'(entry_done);
			list_mem_req <= pend > 0;
		end
	end
endmodule

// ===== sim/tb_command_list_start_stop.sv
/*
 Bench for the command list start/stop interpreter.
 Assumes the checker and the list model are compiled first.
*/
`timescale 1ns/1ns
module tb_command_list_start_stop;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] aw = 8'h00, ar = 8'h00, am, vec, amv;
	logic [31:0] wd = 32'h0, rdat, la, id, pa, pi;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic off = 1'b0, iq = 1'b0;
	logic awr, wrdy, bv, arr, rv, ev, er, ed, mr, run, iv, irq;
	logic [1:0] bresp, rresp;
	logic [2:0] lvl;
	logic [33:0] q[$];
	int pend;
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	clss_top dut(.aclk, .aresetn, .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.entry_valid(ev), .entry_ready(er), .entry_done(ed),
		.list_mem_req(mr), .vme_am(am), .list_addr(la), .list_running(run),
		.irq_level(lvl), .iack_req(iq), .iack_vector(vec), .iack_valid(iv),
		.irq);
	clss_list_model lm(.aclk, .aresetn, .offer(off), .entry_ready(er),
		.entry_valid(ev), .entry_done(ed), .list_mem_req(mr), .pend);
	initial forever #10 aclk = ~aclk;
	task end_sim();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [33:0] s, input logic [33:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("Error t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (rv && rr)
			chk({rresp, rdat}, q.pop_front());
		if (bv && br)
			chk(34'(bresp), q.pop_front());
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		q.push_back(34'h0);
		@(posedge aclk);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
		end while ((awv && !awr) || (wv && !wrdy));
		do @(posedge aclk); while (!bv);
		br <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [33:0] e);
		q.push_back(e);
		@(posedge aclk);
		ar <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		rr <= 1'b0;
	endtask
	// Block goes in through single registers, never the list
	task cmd(input logic [31:0] w04, w08, w0c, w10, sb);
		id = $urandom;
		wr(8'h00, id);
		wr(8'h04, w04);
		wr(8'h08, w08);
		wr(8'h0C, w0c);
		wr(8'h10, w10);
		wr(8'h14, 32'h1);
		while (!irq) @(posedge aclk);
		rd(8'h24, {2'h0, 32'h1});
		rd(8'h18, {2'h0, id});
		rd(8'h1C, {2'h0, sb});
	endtask
	task put();
		@(posedge aclk);
		off <= 1'b1;
		do @(posedge aclk); while (!(ev && er));
		off <= 1'b0;
	endtask
	initial begin
		id = $urandom(32'h2847);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h20, 34'h0);
		rd(8'h40, {2'h2, 32'h0});
		wr(8'h28, 32'h3);
		$display("test reset done");
		cmd(32'hFF, $urandom, 32'h0, 32'h0200_0000, 32'h11C0);
		cmd(32'h0, 32'h0, 32'h0, 32'h0100_0000, 32'h20C0);
		cmd(32'hFF, 32'h0, 32'h0, 32'h0500_0000, 32'h21C0);
		$display("test refusals done");
		pa = $urandom;
		pi = $urandom & 32'h07FF;
		amv = 8'($urandom);
		cmd({16'h0, amv, 8'hFF}, pa, pi, 32'h0100_0000, 32'h80);
		chk(34'(run), 34'h1);
		chk(34'(lvl), 34'(pi[10:8]));
		chk(34'(la), 34'(pa));
		rd(8'h2C, {2'h0, pa});
		rd(8'h30, {10'h0, amv, pi[15:0]});
		@(posedge aclk);
		iq <= 1'b1;
		@(posedge aclk);
		iq <= 1'b0;
		#1;
		chk(34'(iv), 34'h1);
		chk(34'(vec), 34'(pi[7:0]));
		cmd({16'h0, amv, 8'hFF}, pa, pi, 32'h0100_0000, 32'h11C0);
		$display("test start done");
		repeat (3) put();
		wait (mr);
		#1;
		chk(34'(am), 34'(amv));
		cmd(32'hFF, 32'h0, 32'h0, 32'h0200_0000, 32'h80);
		chk(34'(pend), 34'h0);
		chk(34'(run), 34'h0);
		cmd(32'hFF, 32'h0, 32'h0, 32'h0200_0000, 32'h11C0);
		@(posedge aclk);
		off <= 1'b1;
		repeat (3) @(posedge aclk);
		off <= 1'b0;
		rd(8'h24, {2'h0, 32'h2});
		$display("test stop done");
		end_sim();
	end
endmodule
bind clss_top clss_properties u_chk(.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .entry_ready,
	.list_mem_req, .vme_am, .list_addr, .list_running, .irq_level,
	.iack_req, .iack_valid);
